/* rtl/ocpwm_channel.sv */
/*
 * One output compare channel with glitchless PWM, on an AXI4-Lite
 * register slave. Compares the selected time base count against the
 * active and buffered duty values and drives the compare output pin.
 * Assumes the two timers run on CLK_SYS and deliver their counts and
 * period values directly; the fault pin is asynchronous.
 */
// Notes on behaviour
// - Period value N gives N+1 counts
// - Buffered duty copied to active at period match
// - Active duty read-only in PWM modes
// - Active duty at enable sets first period
// - Active duty zero keeps output low
// - Duty above period keeps output high
// - Duty equal period: low one count
// - Idle halt bit freezes channel in idle
// - Fault flag read-only, hardware set, cleared by a control write unless a fault hits in the same cycle
// - Time base select: one second timer
// - 111 PWM with fault, 110 without
// - 101 low then continuous pulses
// - 100 low then one pulse
// - 011 toggles output on match
// - 010 starts high, match forces low
// - 001 starts low, match forces high
// - 000 disables the channel
// - One fault pin shared by two channels
// - Pulse rises on primary, falls secondary
// - Interrupt on the secondary match ending each pulse
// - Time base wraps to zero at period
module ocpwm_channel
  import ocpwm_pkg::*;
(
  input  wire logic              CLK_SYS,
  input  wire logic              RST_N,
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  input  wire logic [15:0]       FIRST_TIMER_COUNT,
  input  wire logic [15:0]       FIRST_TIMER_PERIOD,
  input  wire logic [15:0]       SECOND_TIMER_COUNT,
  input  wire logic [15:0]       SECOND_TIMER_PERIOD,
  input  wire logic              CPU_IDLE,
  input  wire logic              SHARED_FAULT_INPUT,
  output logic                   COMPARE_OUT_PIN,
  output logic                   CHANNEL_IRQ_FLAG
);

  // Merge a 16-bit write under its two byte lanes
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  strb);
    merge16 = {strb[1] ? new_v[15:8] : old_v[15:8],
               strb[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction : merge16

  function automatic logic is_pwm(input ocpwm_mode_t m);
    is_pwm = (m == MODE_PWM) || (m == MODE_PWM_FLT);
  endfunction : is_pwm

  function automatic logic is_pulse(input ocpwm_mode_t m);
    is_pulse = (m == MODE_SINGLE) || (m == MODE_CONT);
  endfunction : is_pulse

  ocpwm_ctrl_t       ctrl_q;
  ocpwm_state_t      state_q;
  logic [15:0]       active_duty_q;
  logic [15:0]       buffered_duty_q;
  logic [15:0]       cnt_prev_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic              aw_vld_q;
  logic [15:0]       wdata_q;
  logic [1:0]        wstrb_q;
  logic              w_vld_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_q;
  logic              flt_meta_q;
  logic              flt_sync_q;
  logic              out_q;
  logic              irq_q;
  logic [15:0]       ctrl_img;
  logic [15:0]       ctrl_new_img;
  ocpwm_mode_t       new_mode;
  ocpwm_mode_t       mode;
  logic [15:0]       time_base_count;
  logic [15:0]       period_reg;
  logic              do_wr;
  logic              ctrl_wr;
  logic              active_wr;
  logic              buffered_wr;
  logic              halt;
  logic              tick;
  logic              ev_pri;
  logic              ev_sec;
  logic              ev_per;
  logic              fault_hit;

  // Control word as software sees it; unused bits read zero
  always_comb begin
    ctrl_img                   = 16'h0000;
    ctrl_img[IDLE_BIT]         = ctrl_q.idle_halt_sel;
    ctrl_img[FLT_BIT]          = ctrl_q.fault_status_flag;
    ctrl_img[TSEL_BIT]         = ctrl_q.time_base_sel;
    ctrl_img[MODE_MSB:0]       = ctrl_q.compare_mode_field;
  end

  assign mode         = ctrl_q.compare_mode_field;
  assign ctrl_new_img = merge16(ctrl_img, wdata_q, wstrb_q);
  assign new_mode     = ocpwm_mode_t'(ctrl_new_img[MODE_MSB:0]);

  assign time_base_count = ctrl_q.time_base_sel ? SECOND_TIMER_COUNT
                                                : FIRST_TIMER_COUNT;
  assign period_reg      = ctrl_q.time_base_sel ? SECOND_TIMER_PERIOD
                                                : FIRST_TIMER_PERIOD;

  assign halt = ctrl_q.idle_halt_sel && CPU_IDLE;

  // Events fire once per new count, so a prescaled timer that dwells
  // on one value does not repeat a match
  assign tick   = time_base_count != cnt_prev_q;
  assign ev_pri = tick && (time_base_count == active_duty_q);
  assign ev_sec = tick && (time_base_count == buffered_duty_q);
  assign ev_per = tick && (time_base_count == period_reg);

  assign fault_hit = !halt && (mode == MODE_PWM_FLT) && flt_sync_q;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cnt_prev_q <= CNT_RST;
    end else begin
      cnt_prev_q <= time_base_count;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      flt_meta_q <= 1'b0;
      flt_sync_q <= 1'b0;
    end else begin
      flt_meta_q <= SHARED_FAULT_INPUT;
      flt_sync_q <= flt_meta_q;
    end
  end

  // Write channel capture; address and data taken in either order
  assign AWREADY = !aw_vld_q && !bvalid_q;
  assign WREADY  = !w_vld_q && !bvalid_q;
  assign do_wr   = aw_vld_q && w_vld_q && !bvalid_q;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      aw_vld_q <= 1'b0;
      awaddr_q <= '0;
      w_vld_q  <= 1'b0;
      wdata_q  <= 16'h0000;
      wstrb_q  <= 2'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_vld_q <= 1'b1;
        awaddr_q <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_vld_q <= 1'b1;
        wdata_q <= WDATA[15:0];
        wstrb_q <= WSTRB[1:0];
      end
      if (do_wr) begin
        aw_vld_q <= 1'b0;
        w_vld_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (ctrl_wr || active_wr || buffered_wr) ? RESP_OKAY
                                                          : RESP_SLVERR;
      end else if (bvalid_q && BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign BVALID = bvalid_q;
  assign BRESP  = bresp_q;

  // Word-aligned decode; low address bits ignored
  assign ctrl_wr     = do_wr && (awaddr_q[11:2] == ADDR_CTRL[11:2]);
  assign active_wr   = do_wr && (awaddr_q[11:2] == ADDR_ACTIVE[11:2]);
  assign buffered_wr = do_wr && (awaddr_q[11:2] == ADDR_BUFFERED[11:2]);

  // Read channel; one read outstanding
  assign ARREADY = !rvalid_q;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (ARVALID && ARREADY) begin
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OKAY;
      unique case (ARADDR[11:2])
        ADDR_CTRL[11:2]:     rdata_q <= {16'h0000, ctrl_img};
        ADDR_ACTIVE[11:2]:   rdata_q <= {16'h0000, active_duty_q};
        ADDR_BUFFERED[11:2]: rdata_q <= {16'h0000, buffered_duty_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  assign RVALID = rvalid_q;
  assign RRESP  = rresp_q;
  assign RDATA  = rdata_q;

  // Control register; fault flag is not writable
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= CTRL_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_q.idle_halt_sel      <= ctrl_new_img[IDLE_BIT];
        ctrl_q.time_base_sel      <= ctrl_new_img[TSEL_BIT];
        ctrl_q.compare_mode_field <= new_mode;
      end
      // hardware set wins over the clear on rewrite
      if (fault_hit) begin
        ctrl_q.fault_status_flag <= 1'b1;
      end else if (ctrl_wr) begin
        ctrl_q.fault_status_flag <= 1'b0;
      end
    end
  end

  // Buffered duty, writable at any time
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      buffered_duty_q <= DUTY_RST;
    end else if (buffered_wr) begin
      buffered_duty_q <= merge16(buffered_duty_q, wdata_q, wstrb_q);
    end
  end

  // Active duty: software loads it outside PWM, hardware reloads it
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      active_duty_q <= DUTY_RST;
    end else if (is_pwm(mode)) begin
      if (ev_per && !halt) begin
        active_duty_q <= buffered_duty_q;
      end
    end else if (active_wr) begin
      active_duty_q <= merge16(active_duty_q, wdata_q, wstrb_q);
    end
  end

  // Pulse sequencer
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
    end else if (ctrl_wr) begin
      state_q <= is_pulse(new_mode) ? ST_RISE : ST_IDLE;
    end else if (!is_pulse(mode)) begin
      state_q <= ST_IDLE;
    end else if (!halt) begin
      unique case (state_q)
        ST_RISE: if (ev_pri) state_q <= ST_FALL;
        ST_FALL: if (ev_sec) begin
          state_q <= (mode == MODE_SINGLE) ? ST_DONE : ST_RISE;
        end
        ST_IDLE: state_q <= ST_IDLE;
        ST_DONE: state_q <= ST_DONE;
      endcase
    end
  end

  // Output pin; a mode write initialises the level first
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      out_q <= 1'b0;
    end else if (ctrl_wr) begin
      out_q <= (new_mode == MODE_SET_LOW);
    end else if (!halt) begin
      unique case (mode)
        MODE_OFF:      out_q <= 1'b0;
        MODE_SET_HIGH: if (ev_pri) out_q <= 1'b1;
        MODE_SET_LOW:  if (ev_pri) out_q <= 1'b0;
        MODE_TOGGLE:   if (ev_pri) out_q <= !out_q;
        MODE_SINGLE, MODE_CONT: begin
          if (state_q == ST_RISE && ev_pri) begin
            out_q <= 1'b1;
          end else if (state_q == ST_FALL && ev_sec) begin
            out_q <= 1'b0;
          end
        end
        // high from count zero until duty
        // boundaries fall out of the compare
        // period spans counts zero to period value
        MODE_PWM:      out_q <= time_base_count < active_duty_q;
        MODE_PWM_FLT:  out_q <= !ctrl_q.fault_status_flag &&
                                !flt_sync_q &&
                                (time_base_count < active_duty_q);
      endcase
    end
  end

  assign COMPARE_OUT_PIN = out_q;

  // event on trailing edge, event on new fault
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= !ctrl_wr && !halt &&
               ((is_pulse(mode) && state_q == ST_FALL && ev_sec) ||
                (fault_hit && !ctrl_q.fault_status_flag));
    end
  end

  assign CHANNEL_IRQ_FLAG = irq_q;

  // Checks
  logic pwm_run;
  assign pwm_run = is_pwm(mode) && !halt && !ctrl_wr;

  property p_zero_duty;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (pwm_run && active_duty_q == 16'h0000) |=> !out_q;
  endproperty
  a_zero_duty: assert property (p_zero_duty)
    else $error("zero duty drove output high");

  property p_full_duty;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (pwm_run && mode == MODE_PWM && active_duty_q > period_reg &&
       time_base_count <= period_reg) |=> out_q;
  endproperty
  a_full_duty: assert property (p_full_duty)
    else $error("duty above period drove output low");

  property p_equal_duty;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (pwm_run && mode == MODE_PWM && active_duty_q == period_reg &&
       time_base_count == period_reg) |=> !out_q;
  endproperty
  a_equal_duty: assert property (p_equal_duty)
    else $error("duty equal period not low at period count");

  property p_reload;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (is_pwm(mode) && ev_per && !halt) |=>
        active_duty_q == $past(buffered_duty_q);
  endproperty
  a_reload: assert property (p_reload)
    else $error("active duty not reloaded at period match");

  property p_duty_locked;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (is_pwm(mode) && !(ev_per && !halt)) |=> $stable(active_duty_q);
  endproperty
  a_duty_locked: assert property (p_duty_locked)
    else $error("active duty changed inside PWM period");

  property p_fault;
    @(posedge CLK_SYS) disable iff (!RST_N)
      fault_hit |=> ctrl_q.fault_status_flag && !out_q;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault did not force output low and flag");

  property p_flag_cause;
    @(posedge CLK_SYS) disable iff (!RST_N)
      $rose(ctrl_q.fault_status_flag) |->
        $past(mode) == MODE_PWM_FLT && $past(flt_sync_q);
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("fault flag set outside fault PWM");

  property p_single_end;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (mode == MODE_SINGLE && state_q == ST_FALL && ev_sec && !halt &&
       !ctrl_wr) |=> state_q == ST_DONE && irq_q && !out_q;
  endproperty
  a_single_end: assert property (p_single_end)
    else $error("single pulse did not end cleanly");

  property p_toggle;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (mode == MODE_TOGGLE && ev_pri && !halt && !ctrl_wr) |=>
        out_q != $past(out_q);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle mode missed a match");

  property p_halt;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (halt && !ctrl_wr) [*2] |=> $stable(out_q) && !irq_q;
  endproperty
  a_halt: assert property (p_halt)
    else $error("channel moved while halted in idle");

  property p_rearm;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (ctrl_wr && is_pulse(new_mode)) |=> !out_q && state_q == ST_RISE;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("pulse mode write did not re-arm low");

  c_pwm_reload: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    is_pwm(mode) && ev_per ##1 out_q);
  c_cont_pulse: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    mode == MODE_CONT && irq_q ##[1:1000] irq_q);
  c_fault: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(ctrl_q.fault_status_flag));

endmodule : ocpwm_channel

/* rtl/ocpwm_pkg.sv */
/*
 * Shared constants and types for the output compare / PWM channel:
 * register byte offsets, control field positions, reset values,
 * channel modes, pulse sequencer states and the control carrier.
 * Assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses.
 */
package ocpwm_pkg;

  // Register byte offsets
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] ADDR_CTRL       = 12'h000;
  localparam logic [11:0] ADDR_ACTIVE     = 12'h004;
  localparam logic [11:0] ADDR_BUFFERED   = 12'h008;

  // Control field positions
  localparam int          IDLE_BIT        = 13;
  localparam int          FLT_BIT         = 4;
  localparam int          TSEL_BIT        = 3;
  localparam int          MODE_MSB        = 2;

  // Reset values
  localparam logic [15:0] DUTY_RST        = 16'h0000;
  localparam logic [15:0] CNT_RST         = 16'h0000;

  // Bus answers
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Channel modes
  typedef enum logic [2:0] {
    MODE_OFF      = 3'h0,
    MODE_SET_HIGH = 3'h1,
    MODE_SET_LOW  = 3'h2,
    MODE_TOGGLE   = 3'h3,
    MODE_SINGLE   = 3'h4,
    MODE_CONT     = 3'h5,
    MODE_PWM      = 3'h6,
    MODE_PWM_FLT  = 3'h7
  } ocpwm_mode_t;

  // Pulse sequencer, Gray along idle-rise-fall-done
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RISE = 2'h1,
    ST_FALL = 2'h3,
    ST_DONE = 2'h2
  } ocpwm_state_t;

  // Control register carrier
  typedef struct packed {
    logic        idle_halt_sel;
    logic        fault_status_flag;
    logic        time_base_sel;
    ocpwm_mode_t compare_mode_field;
  } ocpwm_ctrl_t;

  localparam ocpwm_ctrl_t CTRL_RST = '{1'b0, 1'b0, 1'b0, MODE_OFF};

endpackage : ocpwm_pkg

/* tb/ocpwm_channel_tb.sv */
/*
 * Self-checking bench for the compare channel: AXI4-Lite master,
 * two timers that count only while run is set, and an integer model of pin activity.
 * Assumes the bench owns both timers and the fault pin.
 */
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  n_mismatch++; \
  $display("unexpected %s exp %0h got %0h", nm, (e), (g)); end end

module ocpwm_channel_tb;
  import ocpwm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] P1 = 16'h0007;
  localparam logic [15:0] P2 = 16'h0004;

  logic              CLK_SYS, RST_N, AWVALID, WVALID, BREADY;
  logic              ARVALID, RREADY, AWREADY, WREADY, BVALID;
  logic              ARREADY, RVALID, CPU_IDLE, SHARED_FAULT_INPUT;
  logic              COMPARE_OUT_PIN, CHANNEL_IRQ_FLAG, run, en, clr;
  logic [ADDR_W-1:0] AWADDR, ARADDR;
  logic [31:0]       WDATA, RDATA, rd_d;
  logic [3:0]        WSTRB;
  logic [1:0]        BRESP, RRESP, rsp;
  logic [15:0]       FIRST_TIMER_COUNT, FIRST_TIMER_PERIOD;
  logic [15:0]       SECOND_TIMER_COUNT, SECOND_TIMER_PERIOD;
  int                n_high, n_edge, n_irq, n_mismatch, compares, cycles;
  int                dq[$] = '{0, 3, 7, 9, 6, 3};
  int                sq[$] = '{0, 0, 0, 0, 1, 1};
  int                md[4] = '{1, 2, 3, 0};
  int                eh[4] = '{36, 4, 20, 0};
  int                ee[4] = '{1, 1, 5, 0};

  ocpwm_channel dut (.CLK_SYS, .RST_N, .AWADDR, .AWVALID, .AWREADY,
    .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
    .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
    .FIRST_TIMER_COUNT, .FIRST_TIMER_PERIOD, .SECOND_TIMER_COUNT,
    .SECOND_TIMER_PERIOD, .CPU_IDLE, .SHARED_FAULT_INPUT,
    .COMPARE_OUT_PIN, .CHANNEL_IRQ_FLAG);

  ocpwm_load load (.CLK_SYS, .pin(COMPARE_OUT_PIN), .en, .clr, .n_high,
    .n_edge);

  // 25 MHz system clock
  initial begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end

  // Timers, interrupt tally and hang guard
  // fault handling watches the channel interrupt
  always @(posedge CLK_SYS) begin
    FIRST_TIMER_COUNT <= (!run || FIRST_TIMER_COUNT == P1) ? 16'h0000
                         : FIRST_TIMER_COUNT + 16'h0001;
    SECOND_TIMER_COUNT <= (!run || SECOND_TIMER_COUNT == P2) ? 16'h0000
                          : SECOND_TIMER_COUNT + 16'h0001;
    n_irq <= clr ? 0 : n_irq + ((CHANNEL_IRQ_FLAG === 1'b1) ? 1 : 0);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  // Expected high cycles in a 40-cycle window of steady PWM
  function automatic int exp_pwm(input int d, input int p);
    return (40 / (p + 1)) * ((d < p + 1) ? d : p + 1);
  endfunction : exp_pwm

  task automatic summarize();
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // Write: both address and data offered, each dropped once taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d,
                    output logic [1:0] r);
    bit aw, w, b;
    @(posedge CLK_SYS);
    AWADDR <= a;
    WDATA <= {16'h0000, d};
    WSTRB <= 4'hF;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(negedge CLK_SYS);
      aw = AWVALID && AWREADY;
      w = WVALID && WREADY;
      b = BVALID;
      r = BRESP;
      @(posedge CLK_SYS);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
    end while (!b);
    BREADY <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    bit ar, v;
    @(posedge CLK_SYS);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(negedge CLK_SYS);
      ar = ARVALID && ARREADY;
      v = RVALID;
      d = RDATA;
      r = RRESP;
      @(posedge CLK_SYS);
      if (ar) ARVALID <= 1'b0;
    end while (!v);
    RREADY <= 1'b0;
  endtask : rd

  task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK("rdata", e, d)
  endtask : chk_rd

  // Duty values are loaded while off, before the mode is chosen
  // duty before enable
  task automatic setup(input logic [15:0] c, input logic [15:0] a,
                       input logic [15:0] b);
    wr(ADDR_CTRL, 16'h0000, rsp);
    wr(ADDR_ACTIVE, a, rsp);
    wr(ADDR_BUFFERED, b, rsp);
    wr(ADDR_CTRL, c, rsp);
  endtask : setup

  task automatic clear();
    @(posedge CLK_SYS);
    clr <= 1'b1;
    @(posedge CLK_SYS);
    clr <= 1'b0;
  endtask : clear

  // Timer starts from zero only after the mode is set
  // timer run last
  task automatic win(input int skip, input int n);
    clear();
    run <= 1'b1;
    repeat (skip) @(posedge CLK_SYS);
    en <= 1'b1;
    repeat (n) @(posedge CLK_SYS);
    en <= 1'b0;
    run <= 1'b0;
    // Last sample of the window lands only after this edge settles
    @(negedge CLK_SYS);
  endtask : win

  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
    {AWADDR, ARADDR, WDATA, WSTRB} = '0;
    {FIRST_TIMER_COUNT, SECOND_TIMER_COUNT} = '0;
    FIRST_TIMER_PERIOD = P1;
    SECOND_TIMER_PERIOD = P2;
    {CPU_IDLE, SHARED_FAULT_INPUT, run, en, clr} = '0;
    {n_mismatch, compares, cycles, n_irq} = '0;
    RST_N = 1'b0;
    repeat (2) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    void'($urandom(32'h36d58e23));
    chk_rd(ADDR_CTRL, 32'h0);
    chk_rd(ADDR_ACTIVE, 32'h0);
    chk_rd(ADDR_BUFFERED, 32'h0);
    rd(12'h00C, rd_d, rsp);
    `CHK("rresp", RESP_SLVERR, rsp)
    `CHK("rdata", 32'h0, rd_d)
    wr(12'h00C, 16'hFFFF, rsp);
    `CHK("bresp", RESP_SLVERR, rsp)
    // Duty boundaries on both time bases, then random duties
    for (int i = 0; i < 4; i++) begin
      dq.push_back($urandom_range(9, 0));
      sq.push_back($urandom_range(1, 0));
    end
    foreach (dq[i]) begin
      setup(16'(sq[i] * 8 + 6), 16'(dq[i]), 16'(dq[i]));
      win(8, 40);
      `CHK("high", exp_pwm(dq[i], sq[i] ? P2 : P1), n_high)
    end
    // Double buffering and protected active duty
    setup(16'h0006, 16'h0002, 16'h0002);
    wr(ADDR_BUFFERED, 16'h0006, rsp);
    wr(ADDR_ACTIVE, 16'h0001, rsp);
    chk_rd(ADDR_ACTIVE, 32'h2);
    win(8, 40);
    `CHK("high", exp_pwm(6, P1), n_high)
    chk_rd(ADDR_ACTIVE, 32'h6);
    wr(ADDR_CTRL, 16'h0016, rsp);
    chk_rd(ADDR_CTRL, 32'h6);
    // Fault latches low until the control word is rewritten
    setup(16'h0007, 16'h0003, 16'h0003);
    clear();
    SHARED_FAULT_INPUT <= 1'b1;
    repeat (6) @(posedge CLK_SYS);
    chk_rd(ADDR_CTRL, 32'h17);
    `CHK("irq", 1, n_irq)
    SHARED_FAULT_INPUT <= 1'b0;
    win(8, 40);
    `CHK("high", 0, n_high)
    `CHK("irq", 0, n_irq)
    wr(ADDR_CTRL, 16'h0007, rsp);
    chk_rd(ADDR_CTRL, 32'h7);
    win(8, 40);
    `CHK("high", exp_pwm(3, P1), n_high)
    wr(ADDR_CTRL, 16'h0006, rsp);
    SHARED_FAULT_INPUT <= 1'b1;
    win(8, 40);
    `CHK("high", exp_pwm(3, P1), n_high)
    chk_rd(ADDR_CTRL, 32'h6);
    SHARED_FAULT_INPUT <= 1'b0;
    // Set, clear, toggle and off modes
    for (int i = 0; i < 4; i++) begin
      setup(16'(md[i]), 16'h0003, 16'h0009);
      win(0, 40);
      `CHK("high", eh[i], n_high)
      `CHK("edges", ee[i], n_edge)
    end
    // Single pulse, its silence afterwards, then re-arm
    setup(16'h0002, 16'h0003, 16'h0005);
    wr(ADDR_CTRL, 16'h0004, rsp);
    @(negedge CLK_SYS);
    `CHK("pin", 1'b0, COMPARE_OUT_PIN)
    win(0, 40);
    `CHK("high", 2, n_high)
    `CHK("irq", 1, n_irq)
    win(0, 40);
    `CHK("high", 0, n_high)
    wr(ADDR_CTRL, 16'h0004, rsp);
    win(0, 40);
    `CHK("irq", 1, n_irq)
    `CHK("high", 2, n_high)
    // Continuous pulses, halted and running under idle
    wr(ADDR_CTRL, 16'h0002, rsp);
    wr(ADDR_CTRL, 16'h0005, rsp);
    @(negedge CLK_SYS);
    `CHK("pin", 1'b0, COMPARE_OUT_PIN)
    win(0, 40);
    `CHK("high", 10, n_high)
    `CHK("irq", 5, n_irq)
    wr(ADDR_CTRL, 16'h2005, rsp);
    chk_rd(ADDR_CTRL, 32'h2005);
    CPU_IDLE <= 1'b1;
    win(0, 40);
    `CHK("irq", 0, n_irq)
    `CHK("high", 0, n_high)
    wr(ADDR_CTRL, 16'h0005, rsp);
    win(0, 40);
    `CHK("irq", 5, n_irq)
    `CHK("high", 10, n_high)
    CPU_IDLE <= 1'b0;
    summarize();
  end
endmodule : ocpwm_channel_tb

/* tb/ocpwm_load.sv */
/*
 * External load on the compare output pin: counts high cycles and
 * level changes while enabled.
 * Assumes the pin is a registered level on CLK_SYS.
 */
module ocpwm_load (
  input  wire logic CLK_SYS,
  input  wire logic pin,
  input  wire logic en,
  input  wire logic clr,
  output int        n_high,
  output int        n_edge
);
  timeunit 1ns;
  timeprecision 1ps;

  logic last_q;

  // Sampled at the edge, so every count is one whole cycle
  always @(posedge CLK_SYS) begin
    last_q <= pin;
    if (clr) begin
      n_high <= 0;
      n_edge <= 0;
    end else if (en) begin
      n_high <= n_high + ((pin === 1'b1) ? 1 : 0);
      n_edge <= n_edge + ((pin !== last_q) ? 1 : 0);
    end
  end
endmodule : ocpwm_load
